/* hdl/dac_cmd_pkg.sv */
package dac_cmd_pkg;

  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS  = 16;
  localparam int CTRL_BITS  = 11;
  localparam int COUNT_BITS = 5;

  // link and core timing
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int SYNC_STAGES     = 2;

  localparam logic [COUNT_BITS-1:0] FRAME_COUNT = 5'h18;
  localparam logic [COUNT_BITS-1:0] COUNT_MAX   = 5'h1F;

  // command addresses
  localparam logic [3:0] ADDR_NOP_0        = 4'h0;
  localparam logic [3:0] ADDR_WRITE_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_NOP_5        = 4'h5;
  localparam logic [3:0] ADDR_NOP_6        = 4'h6;
  localparam logic [3:0] ADDR_DATA_RESET   = 4'h7;
  localparam logic [3:0] ADDR_CHAIN        = 4'h9;
  localparam logic [3:0] ADDR_READ_DAC     = 4'hB;
  localparam logic [3:0] ADDR_READ_CTRL    = 4'hC;
  localparam logic [3:0] ADDR_NOP_D        = 4'hD;
  localparam logic [3:0] ADDR_NOP_E        = 4'hE;
  localparam logic [3:0] ADDR_FULL_RESET   = 4'hF;

  // serial_output_chain_control register index
  localparam logic [3:0] CHAIN_CONTROL_OFFSET = 4'h9;

  // field positions
  localparam int CHAIN_DISABLE_POS = 0;
  localparam int RANGE_LSB         = 0;
  localparam int RANGE_MSB         = 2;
  localparam int SEL_LSB           = 3;
  localparam int SEL_MSB           = 4;

  // reset values
  localparam logic                 CHAIN_DISABLE_RESET = 1'b0;
  localparam logic [CTRL_BITS-1:0] CTRL_RESET          = 11'h000;
  localparam logic [DATA_BITS-1:0] CODE_RESET          = 16'h0000;

  // reset_value_select encodings and preset codes
  localparam logic [1:0]           SEL_ZERO   = 2'h0;
  localparam logic [1:0]           SEL_MID    = 2'h1;
  localparam logic [1:0]           SEL_FULL   = 2'h2;
  localparam logic [DATA_BITS-1:0] CODE_ZERO  = 16'h0000;
  localparam logic [DATA_BITS-1:0] CODE_MID   = 16'h8000;
  localparam logic [DATA_BITS-1:0] CODE_FULL  = 16'hFFFF;

  typedef struct packed {
    logic [2:0]           pad;
    logic                 zero;
    logic [3:0]           addr;
    logic [DATA_BITS-1:0] data;
  } frame_t;

  typedef struct packed {
    logic ground_clamp;
    logic buffer_power;
  } analog_ctrl_t;

  typedef enum logic [1:0] {
    ST_CLAMPED = 2'b01,
    ST_ACTIVE  = 2'b10
  } dev_state_t;

  function automatic logic is_noop(input logic [3:0] addr);
    return addr == ADDR_NOP_0 || addr == ADDR_NOP_5 || addr == ADDR_NOP_6
        || addr == ADDR_NOP_D || addr == ADDR_NOP_E;
  endfunction : is_noop

  function automatic logic is_read(input logic [3:0] addr);
    return addr == ADDR_READ_DAC || addr == ADDR_READ_CTRL;
  endfunction : is_read

  function automatic logic [DATA_BITS-1:0] preset_code(
    input logic [1:0] sel
  );
    unique case (sel)
      SEL_MID:  return CODE_MID;
      SEL_FULL: return CODE_FULL;
      default: return CODE_ZERO;
    endcase
  endfunction : preset_code

endpackage : dac_cmd_pkg

/* hdl/frame_receiver.sv */
`timescale 1ns/1ps
module frame_receiver (
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  input  wire logic              sclk_i,
  input  wire logic              sync_n_i,
  input  wire logic              data_i,
  output dac_cmd_pkg::frame_t    frame_o,
  output logic                   frame_valid_o,
  output logic                   bit_strobe_o,
  output logic                   bit_o
);
  import dac_cmd_pkg::*;

  logic [2:0]            sclk_sync;
  logic [2:0]            sync_sync;
  logic [1:0]            data_sync;
  logic [FRAME_BITS-1:0] shift;
  logic [COUNT_BITS-1:0] count;
  logic [FRAME_BITS-1:0] next_shift;
  logic [COUNT_BITS-1:0] next_count;
  logic                  next_valid;
  logic                  next_strobe;
  logic                  in_frame;
  logic                  sclk_fall;
  logic                  sync_rise;

  // edges read stages 2 and 3 only; stage 1 may be metastable
  assign in_frame  = !sync_sync[1];
  assign sclk_fall = !sclk_sync[1] && sclk_sync[2];
  assign sync_rise = sync_sync[1] && !sync_sync[2];

  always_comb begin
    next_shift  = shift;
    next_count  = count;
    next_valid  = 1'b0;
    next_strobe = 1'b0;
    if (in_frame && sclk_fall) begin
      next_shift  = {shift[FRAME_BITS-2:0], data_sync[1]};
      next_strobe = 1'b1;
      if (count != COUNT_MAX) begin
        next_count = count + 5'h01;
      end
    end
    if (sync_rise) begin
      next_valid = (count == FRAME_COUNT);
      next_count = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      // idle high, so leaving reset shows no false edge
      sclk_sync     <= 3'h7;
      sync_sync     <= 3'h7;
      data_sync     <= 2'h0;
      shift         <= '0;
      count         <= '0;
      frame_valid_o <= 1'b0;
      bit_strobe_o  <= 1'b0;
      bit_o         <= 1'b0;
    end else begin
      sclk_sync     <= {sclk_sync[1:0], sclk_i};
      sync_sync     <= {sync_sync[1:0], sync_n_i};
      data_sync     <= {data_sync[0], data_i};
      shift         <= next_shift;
      count         <= next_count;
      frame_valid_o <= next_valid;
      bit_strobe_o  <= next_strobe;
      bit_o         <= data_sync[1];
    end
  end

  assign frame_o = frame_t'(shift);

  a_partial_drop: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    frame_valid_o |-> $past(count) == FRAME_COUNT)
    else $error("frame accepted without 24 bits");

endmodule : frame_receiver

/* hdl/dac_serial_command_decoder.sv */
`timescale 1ns/1ps
// Summary of operation
// - address 1001 sets chain_disable from bit 0
// - one disables daisy chain, zero enables it
// - daisy chain enabled after reset
// - disabled chain tristates output, refuses readback
// - data reset loads preset code from reset_value_select
// - address 1111 clamps output, powers buffer down
// - host control write releases clamp, powers buffer
// - range change in operation forces full reset
// - no-operation addresses change no state
// - 24-bit frames, most significant bit first
// - readback shifts out during following frame
module dac_serial_command_decoder (
  input  wire logic                          clock_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          serial_clock_i,
  input  wire logic                          frame_sync_n_i,
  input  wire logic                          serial_data_in_i,
  output logic                               serial_data_out_o,
  output logic                               serial_data_out_oe_n_o,
  output logic [dac_cmd_pkg::DATA_BITS-1:0]  output_code_o,
  output logic                               ground_clamp_o,
  output logic                               buffer_power_o,
  output logic                               chain_disable_o
);
  import dac_cmd_pkg::*;

  frame_t                frame;
  logic                  frame_valid;
  logic                  bit_strobe;
  logic                  bit_in;

  dev_state_t            state;
  dev_state_t            next_state;
  logic [CTRL_BITS-1:0]  ctrl;
  logic [CTRL_BITS-1:0]  next_ctrl;
  logic [DATA_BITS-1:0]  next_code;
  analog_ctrl_t          next_analog;
  logic                  next_chain_disable;
  logic [FRAME_BITS-1:0] out_shift;
  logic [FRAME_BITS-1:0] next_out_shift;
  logic                  full_reset;
  logic                  ctrl_write;
  logic                  range_change;

  frame_receiver receiver (
    .clock_i       (clock_i),
    .reset_n_i     (reset_n_i),
    .sclk_i        (serial_clock_i),
    .sync_n_i      (frame_sync_n_i),
    .data_i        (serial_data_in_i),
    .frame_o       (frame),
    .frame_valid_o (frame_valid),
    .bit_strobe_o  (bit_strobe),
    .bit_o         (bit_in)
  );

  assign ctrl_write   = frame_valid && frame.addr == ADDR_WRITE_CTRL;
  assign range_change = ctrl_write && state == ST_ACTIVE
      && frame.data[RANGE_MSB:RANGE_LSB] != ctrl[RANGE_MSB:RANGE_LSB];
  assign full_reset   = (frame_valid && frame.addr == ADDR_FULL_RESET)
      || range_change;

  // command decode; no-op and unknown addresses fall through untouched
  always_comb begin
    next_state         = state;
    next_ctrl          = ctrl;
    next_code          = output_code_o;
    next_chain_disable = chain_disable_o;
    next_analog        = '{ground_clamp: ground_clamp_o,
                           buffer_power: buffer_power_o};
    if (full_reset) begin
      next_state         = ST_CLAMPED;
      next_code          = CODE_RESET;
      next_chain_disable = CHAIN_DISABLE_RESET;
      next_analog        = '{ground_clamp: 1'b1, buffer_power: 1'b0};
      // keeps the new range so the next control write releases the clamp
      next_ctrl          = ctrl_write ? frame.data[CTRL_BITS-1:0]
                                      : CTRL_RESET;
    end else if (frame_valid && !is_noop(frame.addr)) begin
      unique case (frame.addr)
        ADDR_WRITE_CTRL: begin
          next_ctrl   = frame.data[CTRL_BITS-1:0];
          next_state  = ST_ACTIVE;
          next_analog = '{ground_clamp: 1'b0, buffer_power: 1'b1};
        end
        CHAIN_CONTROL_OFFSET: begin
          next_chain_disable = frame.data[CHAIN_DISABLE_POS];
        end
        ADDR_DATA_RESET: begin
          next_code = preset_code(ctrl[SEL_MSB:SEL_LSB]);
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  // daisy chain passes input through; readback overwrites the shifter
  always_comb begin
    next_out_shift = out_shift;
    if (frame_valid && is_read(frame.addr) && !chain_disable_o) begin
      next_out_shift = {3'h0, 1'b0, frame.addr,
                        frame.addr == ADDR_READ_CTRL
                          ? {5'h00, ctrl} : output_code_o};
    end else if (bit_strobe) begin
      next_out_shift = {out_shift[FRAME_BITS-2:0], bit_in};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state                  <= ST_CLAMPED;
      ctrl                   <= CTRL_RESET;
      output_code_o          <= CODE_RESET;
      chain_disable_o        <= CHAIN_DISABLE_RESET;
      ground_clamp_o         <= 1'b1;
      buffer_power_o         <= 1'b0;
      out_shift              <= '0;
      serial_data_out_o      <= 1'b0;
      serial_data_out_oe_n_o <= 1'b0;
    end else begin
      state                  <= next_state;
      ctrl                   <= next_ctrl;
      output_code_o          <= next_code;
      chain_disable_o        <= next_chain_disable;
      ground_clamp_o         <= next_analog.ground_clamp;
      buffer_power_o         <= next_analog.buffer_power;
      out_shift              <= next_out_shift;
      serial_data_out_o      <= next_out_shift[FRAME_BITS-1];
      serial_data_out_oe_n_o <= next_chain_disable;
    end
  end

  sequence range_change_write;
    frame_valid && frame.addr == ADDR_WRITE_CTRL && state == ST_ACTIVE
      && frame.data[RANGE_MSB:RANGE_LSB] != ctrl[RANGE_MSB:RANGE_LSB];
  endsequence

  sequence full_reset_cmd;
    frame_valid && frame.addr == ADDR_FULL_RESET;
  endsequence

  sequence clamped_state;
    ground_clamp_o && !buffer_power_o && output_code_o == CODE_RESET;
  endsequence

  a_chain_write: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    frame_valid && frame.addr == ADDR_CHAIN
    |=> chain_disable_o == $past(frame.data[CHAIN_DISABLE_POS]))
    else $error("chain_disable not taken from bit 0");

  a_chain_hold: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    !frame_valid |=> $stable(chain_disable_o))
    else $error("chain_disable changed without a command");

  a_chain_reset: assert property (
    @(posedge clock_i)
    !reset_n_i |=> !chain_disable_o && !serial_data_out_oe_n_o)
    else $error("daisy chain not enabled after reset");

  a_sdo_tristate: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    chain_disable_o |-> serial_data_out_oe_n_o)
    else $error("serial_data_out driven while chain disabled");

  a_read_refused: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    frame_valid && is_read(frame.addr) && chain_disable_o
    |=> out_shift == $past(out_shift))
    else $error("readback accepted while chain disabled");

  a_read_load: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    frame_valid && is_read(frame.addr) && !chain_disable_o
    |=> out_shift[19:16] == $past(frame.addr)
        && serial_data_out_o == 1'b0)
    else $error("readback word not loaded msb first");

  // one bit per link edge; a double shift would skew the whole word
  a_daisy_shift: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    bit_strobe && !frame_valid
    |=> out_shift == {$past(out_shift[FRAME_BITS-2:0]), $past(bit_in)})
    else $error("daisy chain did not shift one bit");

  a_data_reset: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    frame_valid && frame.addr == ADDR_DATA_RESET
    |=> output_code_o == preset_code($past(ctrl[SEL_MSB:SEL_LSB])))
    else $error("data reset code wrong");

  a_full_reset: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    full_reset_cmd |=> clamped_state)
    else $error("full reset did not clamp output");

  a_reset_state: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    full_reset_cmd |=> !chain_disable_o && ctrl == CTRL_RESET
        && state == ST_CLAMPED)
    else $error("full reset left state behind");

  a_ctrl_release: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    ctrl_write && state == ST_CLAMPED
    |=> !ground_clamp_o && buffer_power_o ##1 state == ST_ACTIVE)
    else $error("control write did not release clamp");

  a_range_change: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    range_change_write |=> clamped_state and state == ST_CLAMPED)
    else $error("range change did not force full reset");

  a_range_keep: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    range_change_write |=> ctrl == $past(frame.data[CTRL_BITS-1:0]))
    else $error("range change lost the new control value");

  a_noop_hold: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    frame_valid && is_noop(frame.addr)
    |=> $stable(output_code_o) && $stable(chain_disable_o)
        && $stable(ground_clamp_o) && $stable(ctrl) && $stable(state))
    else $error("no-operation command changed state");

  // partial frames never raise frame_valid, so state must sit still
  a_code_hold: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    !frame_valid |=> $stable(output_code_o) && $stable(ctrl)
        && $stable(state) && $stable(ground_clamp_o)
        && $stable(buffer_power_o))
    else $error("state changed without a complete frame");

endmodule : dac_serial_command_decoder

/* dv/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input  wire logic clock_i,
  output logic      sclk_o,
  output logic      sync_n_o,
  output logic      din_o,
  input  wire logic dout_i
);
  // link clock idles high and stands still between frames
  initial begin
    sclk_o   = 1'b1;
    sync_n_o = 1'b1;
    din_o    = 1'b0;
  end

  // nbits below 24 makes a short frame the device must drop
  task automatic frame(input logic [23:0] word, input int nbits,
                       output logic [23:0] got);
    got = 24'h000000;
    @(negedge clock_i);
    sync_n_o = 1'b0;
    for (int i = 23; i > 23 - nbits; i--) begin
      din_o = word[i];
      repeat (4) @(negedge clock_i);
      got[i] = dout_i;
      sclk_o = 1'b0;
      repeat (4) @(negedge clock_i);
      sclk_o = 1'b1;
    end
    repeat (4) @(negedge clock_i);
    sync_n_o = 1'b1;
    // released data line shows the inverse, not a stale level
    din_o = ~din_o;
    repeat (12) @(negedge clock_i);
  endtask : frame
endmodule : host_model

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import dac_cmd_pkg::*;
  logic                 clock_i   = 1'b0;
  logic                 reset_n_i = 1'b0;
  logic                 sclk;
  logic                 sync_n;
  logic                 din;
  logic                 dout;
  logic                 oe_n;
  logic                 clamp;
  logic                 bpow;
  logic                 chain;
  logic [DATA_BITS-1:0] code;
  logic [23:0]          rd;
  int                   n_mismatch = 0;
  int                   checked    = 0;
  int                   cycles     = 0;
  logic [1:0]           sel_val [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic [15:0]          sel_code[4] = '{CODE_ZERO, CODE_FULL, CODE_ZERO,
                                        CODE_MID};
  logic [3:0]           noops  [5] = '{ADDR_NOP_0, ADDR_NOP_5, ADDR_NOP_6,
                                       ADDR_NOP_D, ADDR_NOP_E};

  always #2 clock_i = ~clock_i;

  host_model host (
    .clock_i  (clock_i),
    .sclk_o   (sclk),
    .sync_n_o (sync_n),
    .din_o    (din),
    .dout_i   (dout)
  );

  dac_serial_command_decoder uut (
    .clock_i                (clock_i),
    .reset_n_i              (reset_n_i),
    .serial_clock_i         (sclk),
    .frame_sync_n_i         (sync_n),
    .serial_data_in_i       (din),
    .serial_data_out_o      (dout),
    .serial_data_out_oe_n_o (oe_n),
    .output_code_o          (code),
    .ground_clamp_o         (clamp),
    .buffer_power_o         (bpow),
    .chain_disable_o        (chain)
  );

  task automatic finish_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // output enable is expected to follow the chain setting
  task automatic chk_state(input logic [15:0] c, input logic cl, bp, cd);
    checked++;
    if ({code, clamp, bpow, chain, oe_n} !== {c, cl, bp, cd, cd}) begin
      n_mismatch++;
      $display("[ERR] %0t state %h want %h", $time,
               {code, clamp, bpow, chain, oe_n}, {c, cl, bp, cd, cd});
    end
  endtask : chk_state

  task automatic chk_word(input logic [23:0] exp);
    checked++;
    if (rd !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t readback word %h want %h", $time, rd, exp);
    end
  endtask : chk_word

  task automatic cmd(input logic [3:0] a, input logic [15:0] d);
    host.frame({4'h0, a, d}, 24, rd);
  endtask : cmd

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      $display("[ERR] %0t run did not finish", $time);
      finish_test();
    end
  end

  initial begin
    repeat (12) @(negedge clock_i);
    reset_n_i = 1'b1;
    @(negedge clock_i);
    chk_state(CODE_RESET, 1'b1, 1'b0, 1'b0);
    cmd(ADDR_WRITE_CTRL, 16'h0000);
    chk_state(CODE_RESET, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cmd(ADDR_WRITE_CTRL, {11'h000, sel_val[i], 3'h0});
      cmd(ADDR_DATA_RESET, 16'h1234);
      chk_state(sel_code[i], 1'b0, 1'b1, 1'b0);
    end
    // readbacks and daisy chain run back to back
    cmd(ADDR_READ_CTRL, 16'h0000);
    cmd(ADDR_READ_DAC, 16'h0000);
    chk_word({4'h0, ADDR_READ_CTRL, 16'h0008});
    cmd(ADDR_NOP_D, 16'h5A5A);
    chk_word({4'h0, ADDR_READ_DAC, CODE_MID});
    cmd(ADDR_NOP_0, 16'h0000);
    chk_word({4'h0, ADDR_NOP_D, 16'h5A5A});
    for (int i = 0; i < 5; i++) begin
      cmd(noops[i], 16'hFFFF);
      chk_state(CODE_MID, 1'b0, 1'b1, 1'b0);
    end
    // one bit short: the full reset must be dropped
    host.frame({4'h0, ADDR_FULL_RESET, 16'h0000}, 23, rd);
    chk_state(CODE_MID, 1'b0, 1'b1, 1'b0);
    cmd(ADDR_CHAIN, 16'hFFFE);
    chk_state(CODE_MID, 1'b0, 1'b1, 1'b0);
    cmd(ADDR_CHAIN, 16'h0001);
    chk_state(CODE_MID, 1'b0, 1'b1, 1'b1);
    cmd(ADDR_READ_CTRL, 16'h0000);
    cmd(ADDR_NOP_0, 16'h0000);
    chk_state(CODE_MID, 1'b0, 1'b1, 1'b1);
    cmd(ADDR_CHAIN, 16'h0000);
    chk_state(CODE_MID, 1'b0, 1'b1, 1'b0);
    cmd(ADDR_CHAIN, 16'h0001);
    chk_word({4'h0, ADDR_CHAIN, 16'h0000});
    cmd(ADDR_FULL_RESET, 16'hFFFF);
    chk_state(CODE_RESET, 1'b1, 1'b0, 1'b0);
    cmd(ADDR_WRITE_CTRL, 16'h0010);
    cmd(ADDR_DATA_RESET, 16'h0000);
    chk_state(CODE_FULL, 1'b0, 1'b1, 1'b0);
    cmd(ADDR_WRITE_CTRL, 16'h0011);
    chk_state(CODE_RESET, 1'b1, 1'b0, 1'b0);
    cmd(ADDR_READ_CTRL, 16'h0000);
    cmd(ADDR_NOP_0, 16'h0000);
    chk_word({4'h0, ADDR_READ_CTRL, 16'h0011});
    finish_test();
  end
endmodule : tb_top
